// ===== sim/sbs_bus_model.sv
// partner model: another party on the two-wire bus, driving both open-drain lines
`timescale 1ns/1ps
module sbs_bus_model (
	// clock
	input  wire logic clock,
	// line drive, 1 releases the line to its pull-up
	output logic      scl_o,
	output logic      sda_o
);
	localparam int HALF = 8; // a third of a bit time in clocks, well above the filter-off delay

	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end

	task automatic idle(input int n);
		repeat (n) @(posedge clock);
	endtask

	// start: data falls while clock stays high
	task automatic bstart();
		idle(HALF);
		sda_o <= 1'b0;
		idle(HALF);
		scl_o <= 1'b0;
	endtask

	// one byte msb first, then the ninth clock; ack pulls data low in it
	task automatic bbyte(input logic [7:0] b, input logic ack);
		for (int i = 8; i >= 0; i--) begin
			idle(HALF);
			sda_o <= (i == 0) ? !ack : b[i-1];
			idle(HALF);
			scl_o <= 1'b1;
			idle(HALF);
			scl_o <= 1'b0;
		end
		idle(2);
		sda_o <= 1'b1; // let go so the device may take the data line
	endtask

	// stop: data rises while clock is high
	task automatic bstop();
		idle(HALF);
		sda_o <= 1'b0;
		idle(HALF);
		scl_o <= 1'b1;
		idle(HALF);
		sda_o <= 1'b1;
		idle(HALF);
	endtask

	// short clock-low pulse, used to trigger the hold logic
	task automatic pull_clock(input int n);
		scl_o <= 1'b0;
		idle(n);
		scl_o <= 1'b1;
	endtask
endmodule

// ===== sim/sbs_status_test.sv
// self-checking bench of the bus status, clock selection and mode block
`timescale 1ns/1ps
module sbs_status_test;
	import sbs_pkg::*;

	typedef struct {logic [15:0] a; logic [7:0] w; logic [7:0] e;} sbs_row_t;
	typedef struct {logic [7:0] sel; logic [7:0] per;} sbs_div_t;

	logic         clock;
	logic         reset;
	sbs_bus_req_t bus;
	logic [7:0]   bus_rdata;
	logic         scl_out, sda_out, scl_oe_n, sda_oe_n;
	logic         master_start_in, arb_lost_in, so_latch;
	logic         start_irq, rate_tick, standby;
	logic         m_scl, m_sda;
	wire          scl_in = m_scl & scl_oe_n;
	wire          sda_in = m_sda & sda_oe_n;
	int           n_mismatch, checked, n_irq;
	logic [7:0]   rv;

	sbs_row_t rows [7] = '{
		'{SBS_ADDR_CLKSEL, 8'h3f, 8'h0f}, '{SBS_ADDR_MODE, 8'h1f, 8'h1f},
		'{SBS_ADDR_SLAVE, 8'ha5, 8'ha4}, '{SBS_ADDR_STATUS, 8'hff, 8'h00},
		'{16'hff70, 8'h5a, 8'h00}, '{SBS_ADDR_CLKSEL, 8'h00, 8'h00},
		'{SBS_ADDR_MODE, 8'h28, 8'h28}};
	sbs_div_t divs [6] = '{'{8'h00, 8'd44}, '{8'h01, 8'd86}, '{8'h02, 8'd172},
		'{8'h08, 8'd24}, '{8'h09, 8'd24}, '{8'h0a, 8'd48}};

	sbs_status i_sbs_status (.clock(clock), .reset(reset), .bus(bus), .bus_rdata(bus_rdata),
		.scl_in(scl_in), .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda_in),
		.sda_out(sda_out), .sda_oe_n(sda_oe_n), .master_start_in(master_start_in),
		.arb_lost_in(arb_lost_in), .so_latch(so_latch), .start_irq(start_irq),
		.rate_tick(rate_tick), .standby(standby));

	sbs_bus_model i_sbs_bus_model (.clock(clock), .scl_o(m_scl), .sda_o(m_sda));

	// clock and start interrupt tally
	always #5 clock = ~clock;
	always @(posedge clock) if (start_irq === 1'b1) n_irq++;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic summarize();
		if (n_mismatch == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one-cycle write strobe
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clock);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clock);
		bus <= '0;
	endtask

	// one-cycle read strobe; data stands in the following cycle only
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(posedge clock);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clock);
		bus <= '0;
		#1 d = bus_rdata;
	endtask

	task automatic pulse(input logic arb);
		@(posedge clock);
		if (arb) arb_lost_in <= 1'b1;
		else master_start_in <= 1'b1;
		@(posedge clock);
		arb_lost_in <= 1'b0;
		master_start_in <= 1'b0;
	endtask

	// bounded wait for the next divider tick, returns cycles waited
	task automatic next_tick(output int n);
		n = 0;
		do begin
			@(posedge clock);
			#1 n++;
			if (n > 400) begin
				n_mismatch++;
				summarize();
			end
		end while (rate_tick !== 1'b1);
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		int n;
		clock = 1'b0;
		reset = 1'b1;
		bus = '0;
		master_start_in = 1'b0;
		arb_lost_in = 1'b0;
		so_latch = 1'b1;
		n_mismatch = 0;
		checked = 0;
		n_irq = 0;
		repeat (16) @(posedge clock);
		reset <= 1'b0;
		// reset values
		rd(SBS_ADDR_STATUS, rv);
		chk(rv, 8'h00);
		rd(SBS_ADDR_CLKSEL, rv);
		chk(rv, 8'h00);
		rd(SBS_ADDR_MODE, rv);
		chk(rv, 8'h20);
		// ordinary register cases, top clock bits kept zero by software
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].w);
			rd(rows[i].a, rv);
			chk(rv, rows[i].e);
		end
		// divider ratio for every legal selector and speed mode
		foreach (divs[i]) begin
			wr(SBS_ADDR_CLKSEL, divs[i].sel);
			next_tick(n);
			next_tick(n);
			next_tick(n);
			chk(8'(n), divs[i].per);
		end
		wr(SBS_ADDR_CLKSEL, 8'h00);
		wr(SBS_ADDR_CONTROL, 8'h80);
		rd(SBS_ADDR_CLKSEL, rv);
		chk(rv, 8'h30);
		// master start, arbitration loss and its clearing by read and by write
		pulse(1'b0);
		rd(SBS_ADDR_STATUS, rv);
		chk(rv, 8'h88);
		pulse(1'b1);
		rd(SBS_ADDR_STATUS, rv);
		chk(rv, 8'h40);
		rd(SBS_ADDR_STATUS, rv);
		chk(rv, 8'h00);
		pulse(1'b1);
		wr(SBS_ADDR_STATUS, 8'h01);
		rd(SBS_ADDR_STATUS, rv);
		chk(rv, 8'h00);
		// addressed as slave, read direction, acknowledged
		n_irq = 0;
		i_sbs_bus_model.bstart();
		i_sbs_bus_model.bbyte(8'ha5, 1'b1);
		rd(SBS_ADDR_STATUS, rv);
		chk(rv, 8'h1e);
		chk(8'(n_irq), 8'h01);
		so_latch <= 1'b0;
		repeat (2) @(posedge clock);
		#1 chk(8'(sda_oe_n), 8'h00);
		so_latch <= 1'b1;
		i_sbs_bus_model.bstop();
		rd(SBS_ADDR_STATUS, rv);
		chk(rv, 8'h01);
		// extension code with start interrupt disabled
		wr(SBS_ADDR_MODE, 8'h20);
		i_sbs_bus_model.bstart();
		i_sbs_bus_model.bbyte(8'hf0, 1'b0);
		rd(SBS_ADDR_STATUS, rv);
		chk(rv, 8'h22);
		chk(8'(n_irq), 8'h01);
		chk(8'(sda_oe_n), 8'h01);
		i_sbs_bus_model.bstop();
		// clock hold waits for a low line, then keeps it low
		wr(SBS_ADDR_MODE, 8'h00);
		repeat (4) @(posedge clock);
		#1 chk(8'(scl_oe_n), 8'h01);
		i_sbs_bus_model.pull_clock(3);
		repeat (4) @(posedge clock);
		#1 chk(8'({scl_oe_n, scl_in}), 8'h00);
		wr(SBS_ADDR_MODE, 8'h20);
		repeat (3) @(posedge clock);
		#1 chk(8'(scl_oe_n), 8'h01);
		// release abandons the transfer as master
		pulse(1'b0);
		wr(SBS_ADDR_CONTROL, 8'hc0);
		rd(SBS_ADDR_STATUS, rv);
		chk(rv & 8'hfe, 8'h00);
		chk(8'({standby, sda_oe_n, scl_oe_n}), 8'h07);
		// filter on: a short low pulse is swallowed, a long one reaches the hold logic
		wr(SBS_ADDR_CLKSEL, 8'h0c);
		wr(SBS_ADDR_MODE, 8'h00);
		i_sbs_bus_model.pull_clock(10);
		repeat (40) @(posedge clock);
		#1 chk(8'(scl_oe_n), 8'h01);
		i_sbs_bus_model.pull_clock(40);
		repeat (2) @(posedge clock);
		#1 chk(8'({scl_oe_n, scl_in}), 8'h00);
		wr(SBS_ADDR_MODE, 8'h20);
		wr(SBS_ADDR_CLKSEL, 8'h00);
		// disable clears levels and the stop flag
		wr(SBS_ADDR_CONTROL, 8'h00);
		rd(SBS_ADDR_CLKSEL, rv);
		chk(rv, 8'h00);
		rd(SBS_ADDR_STATUS, rv);
		chk(rv, 8'h00);
		chk(8'(standby), 8'h00);
		chk(8'({scl_out, sda_out}), 8'h00);
		summarize();
	end
endmodule

// ===== verilog/sbs_pkg.sv
// package: register map, constants and state record of the bus status block
package sbs_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [15:0] SBS_ADDR_CONTROL = 16'hff78;
	localparam logic [15:0] SBS_ADDR_STATUS  = 16'hff79;
	localparam logic [15:0] SBS_ADDR_CLKSEL  = 16'hff7a;
	localparam logic [15:0] SBS_ADDR_SLAVE   = 16'hff7b;
	localparam logic [15:0] SBS_ADDR_MODE    = 16'hff7c;

	// field positions
	localparam int SBS_CTL_ENABLE  = 7;
	localparam int SBS_CTL_RELEASE = 6;
	localparam int SBS_CTL_WREL    = 5;
	localparam int SBS_MODE_HOLD   = 5;
	localparam int SBS_MODE_STIE   = 3;

	// values after reset
	localparam logic [7:0] SBS_RST_STATUS = 8'h00;
	localparam logic [3:0] SBS_RST_CLKSEL = 4'h0;
	localparam logic [5:0] SBS_RST_MODE   = 6'h20;
	localparam logic [7:0] SBS_RST_SLAVE  = 8'h00;

	// clock division ratios, standard and high-speed
	localparam logic [7:0] SBS_DIV_START_DETECTED_FLAG = 8'h2c; // 44
	localparam logic [7:0] SBS_DIV_STD1 = 8'h56; // 86
	localparam logic [7:0] SBS_DIV_STD2 = 8'hac; // 172
	localparam logic [7:0] SBS_DIV_HS0  = 8'h18; // 24
	localparam logic [7:0] SBS_DIV_HS2  = 8'h30; // 48

	// input filter delays, least times rounded up to whole cycles
	localparam int SBS_CLK_MHZ       = 100;
	localparam int SBS_FILT_SHORT_NS = 250;
	localparam int SBS_FILT_LONG_NS  = 500;
	localparam logic [5:0] SBS_FILT_SHORT_CYC = 6'((SBS_FILT_SHORT_NS * SBS_CLK_MHZ + 999) / 1000);
	localparam logic [5:0] SBS_FILT_LONG_CYC  = 6'((SBS_FILT_LONG_NS * SBS_CLK_MHZ + 999) / 1000);

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} sbs_bus_req_t;

	typedef struct packed {
		logic       master_flag;
		logic       arbitration_lost_flag;
		logic       extension_code_flag;
		logic       address_match_flag;
		logic       direction_flag;
		logic       ack_detected_flag;
		logic       start_detected_flag;
		logic       stop_detected_flag;
		logic [3:0] clk_sel;
		logic [5:0] mode;
		logic [7:0] local_slave_address;
		logic       controller_enable;
		logic       standby;
		logic       clock_line_level;
		logic       data_line_level;
		logic       f_scl;
		logic       f_sda;
		logic [5:0] cnt_scl;
		logic [5:0] cnt_sda;
		logic [3:0] bitcnt;
		logic       first_byte;
		logic       data_phase;
		logic [7:0] shreg;
		logic       hold_active;
		logic [7:0] div_cnt;
		logic       rate_tick;
		logic [7:0] rdata;
	} sbs_state_t;

	localparam sbs_state_t SBS_STATE_RESET = '{
		clk_sel: SBS_RST_CLKSEL, mode: SBS_RST_MODE, local_slave_address: SBS_RST_SLAVE,
		f_scl: 1'b1, f_sda: 1'b1, default: '0};

endpackage

// ===== verilog/sbs_status.sv
// bus status, clock selection and mode control logic of the two-wire controller
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
module sbs_status
	import sbs_pkg::*;
(
	// clock and reset
	input  wire logic         clock,
	input  wire logic         reset,
	// register port
	input  wire sbs_bus_req_t bus,
	output logic [7:0]        bus_rdata,
	// bus pins, open drain
	input  wire logic         scl_in,
	output logic              scl_out,
	output logic              scl_oe_n,
	input  wire logic         sda_in,
	output logic              sda_out,
	output logic              sda_oe_n,
	// controller engine side
	input  wire logic         master_start_in,
	input  wire logic         arb_lost_in,
	input  wire logic         so_latch,
	output logic              start_irq,
	output logic              rate_tick,
	output logic              standby
);

	sbs_state_t st;
	sbs_state_t nx;

	// ----------------------------------------------------------------
	// decoded accesses and bus events
	// ----------------------------------------------------------------
	logic wr_ctl, wr_stat, rd_stat, wr_clk, wr_sva, wr_mode;
	logic rel, wrel;
	logic rise, fall, start_ev, stop_ev, first_rise;
	logic [7:0] cur_div;
	logic [5:0] filt_cyc;

	assign wr_ctl     = bus.wr && (bus.addr == SBS_ADDR_CONTROL);
	assign wr_stat    = bus.wr && (bus.addr == SBS_ADDR_STATUS);
	assign rd_stat    = bus.rd && (bus.addr == SBS_ADDR_STATUS);
	assign wr_clk     = bus.wr && (bus.addr == SBS_ADDR_CLKSEL);
	assign wr_sva     = bus.wr && (bus.addr == SBS_ADDR_SLAVE);
	assign wr_mode    = bus.wr && (bus.addr == SBS_ADDR_MODE);
	// release and wait release are one-shot: they act in the write cycle only
	assign rel        = wr_ctl && bus.wdata[SBS_CTL_RELEASE];
	assign wrel       = wr_ctl && bus.wdata[SBS_CTL_WREL];
	// edges of the filtered lines
	assign rise       = nx.f_scl && !st.f_scl;
	assign fall       = !nx.f_scl && st.f_scl;
	assign start_ev   = st.f_scl && nx.f_scl && st.f_sda && !nx.f_sda;
	assign stop_ev    = st.f_scl && nx.f_scl && !st.f_sda && nx.f_sda;
	assign first_rise = rise && (st.bitcnt == 4'h0 || st.bitcnt == 4'h9);

	// ratio from speed mode and selector; selector 11 stops the divider
	always_comb begin
		unique case ({st.clk_sel[3], st.clk_sel[1:0]})
			3'h0:    cur_div = SBS_DIV_START_DETECTED_FLAG;
			3'h1:    cur_div = SBS_DIV_STD1;
			3'h2:    cur_div = SBS_DIV_STD2;
			3'h4:    cur_div = SBS_DIV_HS0;
			3'h5:    cur_div = SBS_DIV_HS0;
			3'h6:    cur_div = SBS_DIV_HS2;
			default: cur_div = 8'h00;
		endcase
	end

	// slowest clock setting gets the longer filter delay
	assign filt_cyc = (st.clk_sel[1:0] == 2'h2) ? SBS_FILT_LONG_CYC : SBS_FILT_SHORT_CYC;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		nx = st;

		// register writes; top two bits of clock select and mode stay zero
		if (wr_ctl) begin
			nx.controller_enable = bus.wdata[SBS_CTL_ENABLE];
		end
		if (wr_clk) begin
			nx.clk_sel = bus.wdata[3:0];
		end
		if (wr_mode) begin
			nx.mode = bus.wdata[5:0];
		end
		if (wr_sva) begin
			nx.local_slave_address = {bus.wdata[7:1], 1'b0};
		end

		// input filter: a new level passes only once stable for the delay
		if (!st.clk_sel[2]) begin
			nx.f_scl   = scl_in;
			nx.f_sda   = sda_in;
			nx.cnt_scl = 6'h00;
			nx.cnt_sda = 6'h00;
		end else begin
			nx.cnt_scl = (scl_in != st.f_scl) ? st.cnt_scl + 6'h01 : 6'h00;
			nx.cnt_sda = (sda_in != st.f_sda) ? st.cnt_sda + 6'h01 : 6'h00;
			if (nx.cnt_scl >= filt_cyc) begin
				nx.f_scl   = scl_in;
				nx.cnt_scl = 6'h00;
			end
			if (nx.cnt_sda >= filt_cyc) begin
				nx.f_sda   = sda_in;
				nx.cnt_sda = 6'h00;
			end
		end

		// transfer clock divider
		nx.rate_tick = 1'b0;
		if (cur_div == 8'h00 || st.div_cnt >= cur_div - 8'h01) begin
			nx.div_cnt   = 8'h00;
			nx.rate_tick = (cur_div != 8'h00);
		end else begin
			nx.div_cnt = st.div_cnt + 8'h01;
		end

		// bit position within the byte, address shift
		if (rise) begin
			nx.shreg  = {st.shreg[6:0], nx.f_sda};
			nx.bitcnt = (st.bitcnt == 4'h9) ? 4'h1 : st.bitcnt + 4'h1;
		end
		if (fall && st.bitcnt == 4'h9 && st.first_byte) begin
			nx.first_byte = 1'b0;
			nx.data_phase = 1'b1;
		end

		// clears tied to the clock edges of the following byte
		if (first_rise) begin
			nx.ack_detected_flag = 1'b0;
			if (!st.first_byte) begin
				nx.start_detected_flag = 1'b0;
			end else begin
				nx.stop_detected_flag = 1'b0;
			end
		end

		// address byte: 8th rising edge
		if (rise && st.bitcnt == 4'h7 && st.first_byte) begin
			if (st.shreg[6:3] == 4'h0 || st.shreg[6:3] == 4'hf) begin
				nx.extension_code_flag = 1'b1;
				nx.standby             = 1'b0;
			end
			if (st.shreg[6:0] == st.local_slave_address[7:1]) begin
				nx.address_match_flag = 1'b1;
				nx.standby            = 1'b0;
			end
			if (nx.f_sda && st.master_flag) begin
				nx.direction_flag = 1'b0;
			end else if (nx.f_sda) begin
				nx.direction_flag = 1'b1;
			end
		end

		// 9th rising edge: acknowledge sample
		if (rise && st.bitcnt == 4'h8 && !nx.f_sda) begin
			nx.ack_detected_flag = 1'b1;
		end

		// start condition
		if (start_ev) begin
			nx.bitcnt              = 4'h0;
			nx.first_byte          = 1'b1;
			nx.data_phase          = 1'b0;
			nx.start_detected_flag = 1'b1;
			nx.extension_code_flag = 1'b0;
			nx.address_match_flag  = 1'b0;
			if (!st.master_flag && !master_start_in) begin
				nx.direction_flag = 1'b0;
			end
		end

		// stop condition
		if (stop_ev) begin
			nx.bitcnt              = 4'h0;
			nx.first_byte          = 1'b0;
			nx.data_phase          = 1'b0;
			nx.stop_detected_flag  = 1'b1;
			nx.start_detected_flag = 1'b0;
			nx.master_flag         = 1'b0;
			nx.extension_code_flag = 1'b0;
			nx.address_match_flag  = 1'b0;
			nx.direction_flag      = 1'b0;
			nx.ack_detected_flag   = 1'b0;
		end

		// wait release ends sending until the next direction decision
		if (wrel) begin
			nx.direction_flag = 1'b0;
		end

		// start generated by the master engine
		if (master_start_in) begin
			nx.master_flag    = 1'b1;
			nx.direction_flag = 1'b1;
			nx.standby        = 1'b0;
		end

		// arbitration-lost flag: software read or any status write clears, a new loss wins
		if (rd_stat) begin
			nx.arbitration_lost_flag = 1'b0;
		end
		if (wr_stat) begin
			nx.arbitration_lost_flag = 1'b0;
		end
		if (arb_lost_in) begin
			nx.arbitration_lost_flag = 1'b1;
			nx.master_flag           = 1'b0;
			nx.direction_flag        = 1'b0;
		end

		// release abandons the transfer and waits for a way back in
		if (rel) begin
			nx.master_flag         = 1'b0;
			nx.extension_code_flag = 1'b0;
			nx.address_match_flag  = 1'b0;
			nx.direction_flag      = 1'b0;
			nx.ack_detected_flag   = 1'b0;
			nx.start_detected_flag = 1'b0;
			nx.data_phase          = 1'b0;
			nx.standby             = 1'b1;
		end

		// clock hold: waits for the line to be low before grabbing it
		if (st.mode[SBS_MODE_HOLD]) begin
			nx.hold_active = 1'b0;
		end else if (!st.f_scl) begin
			nx.hold_active = 1'b1;
		end

		// line levels show only while enabled
		nx.clock_line_level = nx.controller_enable && scl_in;
		nx.data_line_level  = nx.controller_enable && sda_in;

		// disabled: bus flags, bit count, byte phase, standby and hold are dropped
		if (!nx.controller_enable) begin
			nx.master_flag           = 1'b0;
			nx.arbitration_lost_flag = 1'b0;
			nx.extension_code_flag   = 1'b0;
			nx.address_match_flag    = 1'b0;
			nx.direction_flag        = 1'b0;
			nx.ack_detected_flag     = 1'b0;
			nx.start_detected_flag   = 1'b0;
			nx.stop_detected_flag    = 1'b0;
			nx.data_phase            = 1'b0;
			nx.first_byte            = 1'b0;
			nx.bitcnt                = 4'h0;
			nx.standby               = 1'b0;
			nx.hold_active           = 1'b0;
		end

		// read data, one cycle after the strobe; unmapped reads zero
		nx.rdata = 8'h00;
		if (bus.rd) begin
			unique case (bus.addr)
				SBS_ADDR_CONTROL: nx.rdata = {st.controller_enable, 7'h00};
				SBS_ADDR_STATUS:  nx.rdata = {st.master_flag, st.arbitration_lost_flag,
						st.extension_code_flag, st.address_match_flag, st.direction_flag,
						st.ack_detected_flag, st.start_detected_flag, st.stop_detected_flag};
				SBS_ADDR_CLKSEL:  nx.rdata = {2'h0, st.clock_line_level, st.data_line_level,
						st.clk_sel};
				SBS_ADDR_SLAVE:   nx.rdata = st.local_slave_address;
				SBS_ADDR_MODE:    nx.rdata = {2'h0, st.mode};
				default:          nx.rdata = 8'h00;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (reset) begin
			st <= SBS_STATE_RESET;
		end else begin
			st <= nx;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// data drives only while sending and past the address; open drain pulls low
	assign sda_out   = 1'b0;
	assign sda_oe_n  = !(st.direction_flag && st.data_phase && !st.standby && !so_latch);
	assign scl_out   = 1'b0;
	assign scl_oe_n  = !st.hold_active;
	assign bus_rdata = st.rdata;
	assign rate_tick = st.rate_tick;
	assign standby   = st.standby;
	// start event to the interrupt controller, only when enabled
	assign start_irq = start_ev && st.controller_enable && st.mode[SBS_MODE_STIE];

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	AST_MASTER_ARB: assert property (arb_lost_in |=> !st.master_flag && !st.direction_flag)
		else $error("master or direction flag survived arbitration loss");
	AST_ARB_SET: assert property (arb_lost_in && nx.controller_enable |=> st.arbitration_lost_flag)
		else $error("arbitration loss not recorded");
	AST_ARB_RDCLR: assert property (rd_stat && !arb_lost_in |=> !st.arbitration_lost_flag)
		else $error("status read did not clear arbitration flag");
	AST_ARB_WRCLR: assert property (wr_stat && !arb_lost_in |=> !st.arbitration_lost_flag)
		else $error("status write did not clear arbitration flag");
	AST_MASTER_SET: assert property (master_start_in && !arb_lost_in && !rel && nx.controller_enable
		|=> st.master_flag && st.direction_flag)
		else $error("master start did not set master and direction");
	AST_LEVEL_OFF: assert property (!st.controller_enable |-> !st.clock_line_level
		&& !st.data_line_level)
		else $error("line level visible while disabled");
	AST_SDA_RECV: assert property (!st.direction_flag |-> sda_oe_n)
		else $error("data line driven while receiving");
	AST_HOLD: assert property (st.controller_enable && !st.mode[SBS_MODE_HOLD] && !st.f_scl
		&& !wr_ctl && !wr_mode ##1 st.controller_enable |-> !scl_oe_n)
		else $error("clock line not held low");
	AST_TICK_GAP: assert property (rate_tick |=> !rate_tick [*8])
		else $error("divider tick too close");
	AST_STIRQ: assert property (start_irq && !wr_ctl |=> st.start_detected_flag)
		else $error("start interrupt without a recorded start");
	AST_STOP_SET: assert property (stop_ev && nx.controller_enable && !master_start_in
		|=> st.stop_detected_flag && !st.master_flag)
		else $error("stop not recorded");
	AST_RELEASE: assert property (rel && bus.wdata[SBS_CTL_ENABLE] |=> st.standby
		&& !st.master_flag && !st.start_detected_flag
		&& !st.address_match_flag && sda_oe_n)
		else $error("release left transfer state");

	COV_MASTER: cover property (master_start_in ##[1:50] stop_ev);
	COV_ARB: cover property (arb_lost_in ##1 rd_stat);
	COV_MATCH: cover property (!st.address_match_flag ##1 st.address_match_flag);
	COV_START_IRQ: cover property (start_irq);

endmodule
